// ===== inc/iod_pkg.sv
// shared constants and types for the io register space decoder
package iod_pkg;

  // address ranges seen by the core
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] BIT_TOP = 8'h1F;
  localparam logic [7:0] DATA_IO_BASE = 8'h20;
  localparam logic [7:0] DATA_IO_TOP = 8'h5F;
  localparam logic [7:0] EXT_BASE = 8'h60;
  localparam int IO_REG_CNT = 40;
  localparam logic [5:0] IO_REG_LAST = 6'(IO_REG_CNT - 1);
  localparam int EE_TOP_BIT = 11;
  localparam logic [7:0] REG_RESET = 8'h00;

  // io register offsets
  localparam logic [5:0] OFS_PORT_A_PIN_LEVEL = 6'h00;
  localparam logic [5:0] OFS_PORT_A_DIRECTION = 6'h01;
  localparam logic [5:0] OFS_PORT_A_OUTPUT = 6'h02;
  localparam logic [5:0] OFS_PORT_B_PIN_LEVEL = 6'h03;
  localparam logic [5:0] OFS_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] OFS_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] OFS_PORT_C_PIN_LEVEL = 6'h06;
  localparam logic [5:0] OFS_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] OFS_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] OFS_PORT_D_PIN_LEVEL = 6'h09;
  localparam logic [5:0] OFS_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] OFS_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] OFS_PORT_E_PIN_LEVEL = 6'h0C;
  localparam logic [5:0] OFS_PORT_E_DIRECTION = 6'h0D;
  localparam logic [5:0] OFS_PORT_E_OUTPUT = 6'h0E;
  localparam logic [5:0] OFS_PORT_F_PIN_LEVEL = 6'h0F;
  localparam logic [5:0] OFS_PORT_F_DIRECTION = 6'h10;
  localparam logic [5:0] OFS_PORT_F_OUTPUT = 6'h11;
  localparam logic [5:0] OFS_PORT_G_PIN_LEVEL = 6'h12;
  localparam logic [5:0] OFS_PORT_G_DIRECTION = 6'h13;
  localparam logic [5:0] OFS_PORT_G_OUTPUT = 6'h14;
  localparam logic [5:0] OFS_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] OFS_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] OFS_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] OFS_TIMER3_FLAGS = 6'h18;
  localparam logic [5:0] OFS_EXTERNAL_IRQ_FLAGS = 6'h1C;
  localparam logic [5:0] OFS_EXTERNAL_IRQ_MASK = 6'h1D;
  localparam logic [5:0] OFS_GENERAL_PURPOSE_ZERO = 6'h1E;
  localparam logic [5:0] OFS_EEPROM_CONTROL = 6'h1F;
  localparam logic [5:0] OFS_EEPROM_DATA = 6'h20;
  localparam logic [5:0] OFS_EEPROM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] OFS_EEPROM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] OFS_GENERAL_TIMER_CONTROL = 6'h23;
  localparam logic [5:0] OFS_TIMER0_CONTROL = 6'h24;
  localparam logic [5:0] OFS_RSVD_GAP = 6'h25;
  localparam logic [5:0] OFS_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] OFS_TIMER0_COMPARE_A = 6'h27;

  // implemented bits per register
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] PORT_G_MASK = 8'h1F;
  localparam logic [7:0] TMR8_FLAG_MASK = 8'h03;
  localparam logic [7:0] TMR16_FLAG_MASK = 8'h2F;
  localparam logic [7:0] EE_HIGH_MASK = 8'h0F;
  localparam logic [7:0] EE_CTRL_MASK = 8'h0F;
  localparam logic [7:0] GTC_MASK = 8'h83;
  localparam logic [7:0] TC0_CTRL_MASK = 8'h7F;

  // access classes, one-hot
  typedef enum logic [7:0] {
    KIND_IO_IN = 8'h01,
    KIND_IO_OUT = 8'h02,
    KIND_DATA_LOAD = 8'h04,
    KIND_DATA_STORE = 8'h08,
    KIND_SET_BIT = 8'h10,
    KIND_CLR_BIT = 8'h20,
    KIND_SKIP_SET = 8'h40,
    KIND_SKIP_CLR = 8'h80
  } iod_kind_t;

  typedef struct packed {
    iod_kind_t kind;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iod_req_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic ext;
    logic skip;
    logic [7:0] rdata;
  } iod_rsp_t;

  typedef struct packed {
    logic hit;
    logic refused;
    logic ext;
    logic [5:0] io;
  } iod_dec_t;

endpackage : iod_pkg

// ===== rtl/iod_io_decoder.sv
// io register space decoder with bit access and write-one-to-clear flags
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1: set and clear bit instructions act only on io addresses 0x00 to 0x1F.
// RL2: skip instructions test any single bit of a low range register.
// RL3: timer and external flags clear on writing one; writing zero keeps them.
// RL4: a bit set or clear changes only the addressed bit.
// RL5: io in and out instructions use io addresses 0x00 to 0x3F.
// RL6: loads and stores see each io register at io address plus 0x20.
// RL7: data addresses 0x60 to 0xFF are for loads and stores only.
// RL8: software should write zero into reserved bit positions.
// RL9: software must never write reserved io addresses.
// RL10: eeprom address bits above the top implemented bit are ignored.
// RL11: reserved addresses and bits read zero; writes to them do nothing.
////////////////////////////////////////////////////////////////////////
module iod_io_decoder (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire iod_pkg::iod_req_t req_i,
  input wire logic [6:0][7:0] pin_level_i,
  input wire logic [4:0][7:0] flag_set_i,
  output var iod_pkg::iod_rsp_t rsp_o,
  output logic [iod_pkg::IO_REG_CNT-1:0][7:0] io_reg_o,
  output logic [iod_pkg::EE_TOP_BIT:0] eeprom_addr_o
);

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // map an access class and address onto an io index
  function automatic iod_pkg::iod_dec_t decode(
    input iod_pkg::iod_kind_t kind,
    input logic [7:0] addr
  );
    iod_pkg::iod_dec_t d;
    d = '0;
    case (kind)
      iod_pkg::KIND_IO_IN, iod_pkg::KIND_IO_OUT: begin
        d.hit = (addr <= iod_pkg::IO_TOP); // RL5
        d.refused = ~d.hit; // RL7
        d.io = addr[5:0];
      end
      iod_pkg::KIND_DATA_LOAD, iod_pkg::KIND_DATA_STORE: begin
        d.hit = (addr >= iod_pkg::DATA_IO_BASE) &&
                (addr <= iod_pkg::DATA_IO_TOP);
        d.ext = (addr >= iod_pkg::EXT_BASE); // RL7
        d.io = 6'(addr - iod_pkg::DATA_IO_BASE); // RL6
      end
      iod_pkg::KIND_SET_BIT, iod_pkg::KIND_CLR_BIT,
      iod_pkg::KIND_SKIP_SET, iod_pkg::KIND_SKIP_CLR: begin
        d.hit = (addr <= iod_pkg::BIT_TOP); // RL1 RL2
        d.refused = ~d.hit; // RL1
        d.io = addr[5:0];
      end
      default: begin
        d.refused = 1'b1;
      end
    endcase
    return d;
  endfunction : decode

  // software writable storage bits of each register
  function automatic logic [7:0] wr_mask(input logic [5:0] io);
    case (io)
      iod_pkg::OFS_PORT_A_DIRECTION, iod_pkg::OFS_PORT_A_OUTPUT,
      iod_pkg::OFS_PORT_B_DIRECTION, iod_pkg::OFS_PORT_B_OUTPUT,
      iod_pkg::OFS_PORT_C_DIRECTION, iod_pkg::OFS_PORT_C_OUTPUT,
      iod_pkg::OFS_PORT_D_DIRECTION, iod_pkg::OFS_PORT_D_OUTPUT,
      iod_pkg::OFS_PORT_E_DIRECTION, iod_pkg::OFS_PORT_E_OUTPUT,
      iod_pkg::OFS_PORT_F_DIRECTION, iod_pkg::OFS_PORT_F_OUTPUT,
      iod_pkg::OFS_EXTERNAL_IRQ_MASK, iod_pkg::OFS_GENERAL_PURPOSE_ZERO,
      iod_pkg::OFS_EEPROM_DATA, iod_pkg::OFS_EEPROM_ADDRESS_LOW,
      iod_pkg::OFS_TIMER0_COUNT, iod_pkg::OFS_TIMER0_COMPARE_A:
        return iod_pkg::FULL_MASK;
      iod_pkg::OFS_PORT_G_DIRECTION, iod_pkg::OFS_PORT_G_OUTPUT:
        return iod_pkg::PORT_G_MASK;
      iod_pkg::OFS_EEPROM_ADDRESS_HIGH:
        return iod_pkg::EE_HIGH_MASK; // RL10
      iod_pkg::OFS_EEPROM_CONTROL:
        return iod_pkg::EE_CTRL_MASK;
      iod_pkg::OFS_GENERAL_TIMER_CONTROL:
        return iod_pkg::GTC_MASK;
      iod_pkg::OFS_TIMER0_CONTROL:
        return iod_pkg::TC0_CTRL_MASK;
      default:
        return 8'h00; // RL11
    endcase
  endfunction : wr_mask

  // flag bits that clear on a written one
  function automatic logic [7:0] flag_mask(input logic [5:0] io);
    case (io)
      iod_pkg::OFS_TIMER0_FLAGS, iod_pkg::OFS_TIMER2_FLAGS:
        return iod_pkg::TMR8_FLAG_MASK;
      iod_pkg::OFS_TIMER1_FLAGS, iod_pkg::OFS_TIMER3_FLAGS:
        return iod_pkg::TMR16_FLAG_MASK;
      iod_pkg::OFS_EXTERNAL_IRQ_FLAGS:
        return iod_pkg::FULL_MASK;
      default:
        return 8'h00;
    endcase
  endfunction : flag_mask

  // slot of the flag set input feeding a flag register, msb = valid
  function automatic logic [3:0] flag_slot(input logic [5:0] io);
    case (io)
      iod_pkg::OFS_TIMER0_FLAGS: return 4'h8;
      iod_pkg::OFS_TIMER1_FLAGS: return 4'h9;
      iod_pkg::OFS_TIMER2_FLAGS: return 4'hA;
      iod_pkg::OFS_TIMER3_FLAGS: return 4'hB;
      iod_pkg::OFS_EXTERNAL_IRQ_FLAGS: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : flag_slot

  // port whose pin levels sit at an offset, msb = valid
  function automatic logic [3:0] pin_port(input logic [5:0] io);
    case (io)
      iod_pkg::OFS_PORT_A_PIN_LEVEL: return 4'h8;
      iod_pkg::OFS_PORT_B_PIN_LEVEL: return 4'h9;
      iod_pkg::OFS_PORT_C_PIN_LEVEL: return 4'hA;
      iod_pkg::OFS_PORT_D_PIN_LEVEL: return 4'hB;
      iod_pkg::OFS_PORT_E_PIN_LEVEL: return 4'hC;
      iod_pkg::OFS_PORT_F_PIN_LEVEL: return 4'hD;
      iod_pkg::OFS_PORT_G_PIN_LEVEL: return 4'hE;
      default: return 4'h0;
    endcase
  endfunction : pin_port

  ////////////////////////////////////////////////////////////////////////
  // state and read path

  logic [iod_pkg::IO_REG_CNT-1:0][7:0] regs;
  logic [iod_pkg::IO_REG_CNT-1:0][7:0] next_regs;
  iod_pkg::iod_rsp_t next_rsp;
  iod_pkg::iod_dec_t dec;
  logic acc;
  logic wr_acc;
  logic io_op;
  logic data_op;
  logic bit_op;
  logic skip_op;
  logic read_op;
  logic [7:0] bmask;
  logic [7:0] cur_rd;
  logic [7:0] upd_m;
  logic [7:0] upd_v;
  logic [7:0] clr;
  logic [7:0] set_b;
  logic [7:0] wm;
  logic [7:0] fm;
  logic [3:0] slot;
  logic [3:0] pin_sel;
  logic [15:0] ee_full;

  // classify the request
  assign io_op = (req_i.kind == iod_pkg::KIND_IO_IN) ||
                 (req_i.kind == iod_pkg::KIND_IO_OUT);
  assign data_op = (req_i.kind == iod_pkg::KIND_DATA_LOAD) ||
                   (req_i.kind == iod_pkg::KIND_DATA_STORE);
  assign bit_op = (req_i.kind == iod_pkg::KIND_SET_BIT) ||
                  (req_i.kind == iod_pkg::KIND_CLR_BIT);
  assign skip_op = (req_i.kind == iod_pkg::KIND_SKIP_SET) ||
                   (req_i.kind == iod_pkg::KIND_SKIP_CLR);
  assign read_op = (req_i.kind == iod_pkg::KIND_IO_IN) ||
                   (req_i.kind == iod_pkg::KIND_DATA_LOAD) || skip_op;
  assign dec = decode(req_i.kind, req_i.addr);
  assign acc = req_valid_i && dec.hit && (dec.io <= iod_pkg::IO_REG_LAST);
  assign wr_acc = acc && !read_op;
  assign bmask = 8'h01 << req_i.bit_sel;
  assign pin_sel = pin_port(dec.io);

  // current value of the addressed register, reserved bits as zero
  always_comb begin : read_mux
    cur_rd = 8'h00; // RL11
    if (pin_sel[3]) begin
      cur_rd = pin_level_i[pin_sel[2:0]];
      if (pin_sel[2:0] == 3'h6) begin
        cur_rd = cur_rd & iod_pkg::PORT_G_MASK;
      end
    end else if (dec.io <= iod_pkg::IO_REG_LAST) begin
      cur_rd = regs[dec.io] & (wr_mask(dec.io) | flag_mask(dec.io));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register update

  // how the write touches storage: whole byte or one bit
  always_comb begin : write_shape
    upd_m = iod_pkg::FULL_MASK;
    upd_v = req_i.wdata;
    clr = req_i.wdata; // RL3
    case (req_i.kind)
      iod_pkg::KIND_SET_BIT: begin
        upd_m = bmask; // RL4
        upd_v = iod_pkg::FULL_MASK;
        clr = bmask; // RL4
      end
      iod_pkg::KIND_CLR_BIT: begin
        upd_m = bmask; // RL4
        upd_v = 8'h00;
        clr = 8'h00; // RL3
      end
      default: begin
        upd_m = iod_pkg::FULL_MASK;
      end
    endcase
  end

  // next register contents; a hardware set beats a same-cycle clear
  always_comb begin : next_state
    next_regs = regs;
    set_b = 8'h00;
    wm = 8'h00;
    fm = 8'h00;
    slot = 4'h0;
    for (int i = 0; i < iod_pkg::IO_REG_CNT; i++) begin
      wm = wr_mask(6'(i));
      fm = flag_mask(6'(i));
      slot = flag_slot(6'(i));
      set_b = slot[3] ? (flag_set_i[slot[2:0]] & fm) : 8'h00;
      if (wr_acc && (dec.io == 6'(i))) begin
        next_regs[i] = (regs[i] & ~(upd_m & wm)) | (upd_v & upd_m & wm);
        next_regs[i] = next_regs[i] & ~(clr & fm); // RL3
      end
      next_regs[i] = next_regs[i] | set_b;
    end
  end

  // response for the request taken this cycle
  always_comb begin : next_answer
    next_rsp = '0;
    next_rsp.valid = req_valid_i;
    next_rsp.refused = req_valid_i && dec.refused; // RL1 RL5
    next_rsp.ext = req_valid_i && dec.ext; // RL7
    if (acc && read_op) begin
      next_rsp.rdata = cur_rd; // RL6
    end
    if (acc && skip_op) begin
      next_rsp.skip = cur_rd[req_i.bit_sel] ^
                      (req_i.kind == iod_pkg::KIND_SKIP_CLR); // RL2
    end
  end

  // registers
  always_ff @(posedge ref_clk_i) begin : regs_ff
    if (!rst_n_i) begin
      regs <= {iod_pkg::IO_REG_CNT{iod_pkg::REG_RESET}};
      rsp_o <= '0;
    end else begin
      regs <= next_regs;
      rsp_o <= next_rsp;
    end
  end

  // outputs to the peripherals
  assign io_reg_o = regs;
  assign ee_full = {regs[iod_pkg::OFS_EEPROM_ADDRESS_HIGH],
                    regs[iod_pkg::OFS_EEPROM_ADDRESS_LOW]};
  assign eeprom_addr_o = ee_full[iod_pkg::EE_TOP_BIT:0]; // RL10

  ////////////////////////////////////////////////////////////////////////
  // checks

  // helper values sampled by the checks below
  logic bit_val;
  logic skip_clr;
  logic [7:0] sel_store;
  assign bit_val = cur_rd[req_i.bit_sel];
  assign skip_clr = (req_i.kind == iod_pkg::KIND_SKIP_CLR);
  assign sel_store = (dec.io <= iod_pkg::IO_REG_LAST) ? regs[dec.io] : 8'h00;

  // all checks run on the core clock and rest while reset is low
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_bit_range_refuse: assert property ( // RL1
    (req_valid_i && bit_op && (req_i.addr > iod_pkg::BIT_TOP))
    |=> rsp_o.refused && (regs == $past(regs) || $past(|flag_set_i)))
    else $error("bit access above low range not refused");

  a_skip_result: assert property ( // RL2
    (req_valid_i && skip_op && (req_i.addr <= iod_pkg::BIT_TOP))
    |=> rsp_o.valid && (rsp_o.skip == ($past(bit_val) ^ $past(skip_clr))))
    else $error("skip result does not match tested bit");

  a_w1c_clear: assert property ( // RL3
    (req_valid_i && (req_i.kind == iod_pkg::KIND_IO_OUT) &&
     (req_i.addr == {2'b00, iod_pkg::OFS_TIMER0_FLAGS}) &&
     req_i.wdata[0] && !flag_set_i[0][0])
    |=> !regs[iod_pkg::OFS_TIMER0_FLAGS][0])
    else $error("flag not cleared by written one");

  a_w1c_zero_keep: assert property ( // RL3
    (req_valid_i && (req_i.kind == iod_pkg::KIND_IO_OUT) &&
     (req_i.addr == {2'b00, iod_pkg::OFS_EXTERNAL_IRQ_FLAGS}) &&
     (req_i.wdata == 8'h00))
    |=> regs[iod_pkg::OFS_EXTERNAL_IRQ_FLAGS] ==
        ($past(regs[iod_pkg::OFS_EXTERNAL_IRQ_FLAGS]) | $past(flag_set_i[4])))
    else $error("written zero changed a flag");

  // a flag set by hardware survives a same-cycle written one
  a_set_beats_clear: assert property ( // RL3
    (wr_acc && (dec.io == iod_pkg::OFS_EXTERNAL_IRQ_FLAGS) &&
     (flag_set_i[4] != 8'h00))
    |=> ((regs[iod_pkg::OFS_EXTERNAL_IRQ_FLAGS] & $past(flag_set_i[4])) ==
         $past(flag_set_i[4])))
    else $error("hardware flag set lost to a written one");

  a_bit_only: assert property ( // RL4
    (acc && bit_op && (flag_set_i == '0))
    |=> ((regs[$past(dec.io)] ^ $past(sel_store)) & ~$past(bmask)) == 8'h00)
    else $error("bit access disturbed other bits");

  a_io_range: assert property ( // RL5
    (req_valid_i && io_op && (req_i.addr > iod_pkg::IO_TOP))
    |=> rsp_o.refused && (rsp_o.rdata == 8'h00))
    else $error("io access above 0x3F not refused");

  a_data_map: assert property ( // RL6
    (req_valid_i && (req_i.kind == iod_pkg::KIND_DATA_LOAD) &&
     (req_i.addr == ({2'b00, iod_pkg::OFS_PORT_A_DIRECTION} +
                     iod_pkg::DATA_IO_BASE)))
    |=> rsp_o.rdata == $past(regs[iod_pkg::OFS_PORT_A_DIRECTION]))
    else $error("data space load not mapped at io plus 0x20");

  a_ext_region: assert property ( // RL7
    (req_valid_i && (req_i.addr >= iod_pkg::EXT_BASE))
    |=> (rsp_o.ext == $past(data_op)) &&
        (rsp_o.refused == $past(io_op || bit_op || skip_op)))
    else $error("extended region reached by wrong class");

  // the extended region lives elsewhere and leaves these registers alone
  a_ext_no_write: assert property ( // RL7
    (req_valid_i && data_op && (req_i.addr >= iod_pkg::EXT_BASE) &&
     (flag_set_i == '0))
    |=> io_reg_o == $past(io_reg_o))
    else $error("extended region access changed an io register");

  a_ee_addr_mask: assert property ( // RL10
    (acc && (req_i.kind == iod_pkg::KIND_IO_OUT) &&
     (req_i.addr == {2'b00, iod_pkg::OFS_EEPROM_ADDRESS_HIGH}))
    |=> (eeprom_addr_o[11:8] == $past(req_i.wdata[3:0])) &&
        (io_reg_o[iod_pkg::OFS_EEPROM_ADDRESS_HIGH][7:4] == 4'h0))
    else $error("eeprom address upper bits not ignored");

  a_reserved_read: assert property ( // RL11
    (req_valid_i && io_op && (req_i.addr == {2'b00, iod_pkg::OFS_RSVD_GAP}))
    |=> rsp_o.valid && (rsp_o.rdata == 8'h00) &&
        (regs[iod_pkg::OFS_RSVD_GAP] == 8'h00))
    else $error("reserved address not zero");

  // scenarios that the bench should reach
  c_skip_taken: cover property (
    (acc && skip_op) ##1 rsp_o.skip);

  c_flag_cleared: cover property (
    (wr_acc && ((req_i.wdata & flag_mask(dec.io)) != 8'h00)));

  c_set_beats_clear: cover property (
    (wr_acc && (dec.io == iod_pkg::OFS_EXTERNAL_IRQ_FLAGS) &&
     ((req_i.wdata & flag_set_i[4]) != 8'h00)));

  c_ext_access: cover property (req_valid_i && dec.ext);

  c_bit_refused: cover property (req_valid_i && bit_op && dec.refused);

endmodule : iod_io_decoder
`default_nettype wire

// ===== verification/iod_core_model.sv
// processor core model issuing io and data space accesses
`timescale 1ns/10ps
`default_nettype none
module iod_core_model (
  input wire logic ref_clk_i,
  output logic req_valid_o,
  output var iod_pkg::iod_req_t req_o,
  input wire iod_pkg::iod_rsp_t rsp_i
);
  ////////////////////////////////////////////////////////////////////////
  // one access: drive after an edge, hold over the taking edge, then take
  // the answer that stands in the following cycle
  task automatic access(input iod_pkg::iod_kind_t kind,
    input logic [7:0] addr, input logic [2:0] bit_sel,
    input logic [7:0] wdata, output iod_pkg::iod_rsp_t rsp);
    @(posedge ref_clk_i);
    #1;
    req_o = '{kind: kind, addr: addr, bit_sel: bit_sel, wdata: wdata};
    req_valid_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rsp = rsp_i;
    req_valid_o = 1'b0;
    req_o = ~req_o; // released lines must not keep the last value
  endtask : access

  // idle bus at time zero
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
endmodule : iod_core_model
`default_nettype wire

// ===== verification/iod_io_decoder_bench.sv
// self-checking bench for the io register space decoder
`timescale 1ns/10ps
`default_nettype none
module iod_io_decoder_bench;
  logic ref_clk;
  logic rst_n;
  logic req_valid;
  iod_pkg::iod_req_t req;
  iod_pkg::iod_rsp_t rsp_w;
  iod_pkg::iod_rsp_t rsp;
  logic [6:0][7:0] pins;
  logic [4:0][7:0] flag_set;
  logic [iod_pkg::IO_REG_CNT-1:0][7:0] io_reg;
  logic [iod_pkg::EE_TOP_BIT:0] ee_addr;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] v;
  logic [7:0] wd;
  logic isp;
  logic rsv;
  iod_pkg::iod_kind_t wk;

  iod_io_decoder dut_u (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
    .req_i(req), .pin_level_i(pins), .flag_set_i(flag_set),
    .rsp_o(rsp_w), .io_reg_o(io_reg), .eeprom_addr_o(ee_addr)
  );

  iod_core_model core_u (
    .ref_clk_i(ref_clk), .req_valid_o(req_valid), .req_o(req),
    .rsp_i(rsp_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare, access, read-and-compare, flag pulse, verdict
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input iod_pkg::iod_kind_t k, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d);
    core_u.access(k, a, b, d, rsp);
    chk(rsp.valid, 1'b1);
  endtask : acc

  task automatic rdchk(input iod_pkg::iod_kind_t k, input logic [7:0] a,
    input logic [7:0] exp);
    acc(k, a, 3'h0, 8'h00);
    chk(rsp.rdata, exp);
  endtask : rdchk

  task automatic pulse(input int i, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    flag_set[i] = d;
    @(posedge ref_clk);
    #1;
    flag_set[i] = 8'h00;
  endtask : pulse

  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // read value expected at io offset o after writing d there
  function automatic logic [7:0] expv(input int o, input logic [7:0] d);
    logic [7:0] m;
    m = iod_pkg::FULL_MASK;
    case (o)
      6'h00, 6'h03, 6'h06, 6'h09, 6'h0C, 6'h0F: return pins[o/3];
      6'h12: return pins[6] & iod_pkg::PORT_G_MASK;
      6'h15, 6'h16, 6'h17, 6'h18, 6'h1C: return 8'h00;
      6'h19, 6'h1A, 6'h1B, 6'h25: m = 8'h00;
      6'h13, 6'h14: m = iod_pkg::PORT_G_MASK;
      6'h1F: m = iod_pkg::EE_CTRL_MASK;
      6'h22: m = iod_pkg::EE_HIGH_MASK;
      6'h23: m = iod_pkg::GTC_MASK;
      6'h24: m = iod_pkg::TC0_CTRL_MASK;
      default: ;
    endcase
    return d & m;
  endfunction : expv

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test;
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    flag_set = '0;
    pins = 56'h77665544332211;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // reset contents and pin levels through io reads
    for (int o = 0; o < 40; o++) begin
      rdchk(iod_pkg::KIND_IO_IN, 8'(o), expv(o, 8'h00));
    end
    // io writes read back through data space, then the reverse
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < 40; o++) begin
        // second pass keeps reserved bits zero
        wd = p ? expv(o, 8'h5A) : 8'hFF;
        isp = (o < 19) && (o % 3 == 0);
        // reserved offsets are only read, never written
        rsv = ((o > 24) && (o < 28)) || (o == 37);
        if (p == 0) begin
          wk = rsv ? iod_pkg::KIND_IO_IN : iod_pkg::KIND_IO_OUT;
          acc(wk, 8'(o), 3'h0, wd);
          rdchk(iod_pkg::KIND_DATA_LOAD, 8'(o + 32), expv(o, wd));
        end else begin
          wk = rsv ? iod_pkg::KIND_DATA_LOAD : iod_pkg::KIND_DATA_STORE;
          acc(wk, 8'(o + 32), 3'h0, wd);
          rdchk(iod_pkg::KIND_IO_IN, 8'(o), expv(o, wd));
        end
        chk(io_reg[o], isp ? 8'h00 : expv(o, wd));
      end
    end
    // eeprom address bits above the top bit are dropped
    acc(iod_pkg::KIND_IO_OUT, 8'h22, 3'h0, 8'hFF);
    acc(iod_pkg::KIND_IO_OUT, 8'h21, 3'h0, 8'h34);
    chk(ee_addr, 12'hF34);
    // write-one-to-clear flags and bit access on them
    pulse(1, 8'hFF);
    rdchk(iod_pkg::KIND_IO_IN, 8'h16, 8'h2F);
    acc(iod_pkg::KIND_IO_OUT, 8'h16, 3'h0, 8'h01);
    rdchk(iod_pkg::KIND_IO_IN, 8'h16, 8'h2E);
    acc(iod_pkg::KIND_IO_OUT, 8'h16, 3'h0, 8'h00);
    rdchk(iod_pkg::KIND_IO_IN, 8'h16, 8'h2E);
    acc(iod_pkg::KIND_SET_BIT, 8'h16, 3'h3, 8'h00);
    rdchk(iod_pkg::KIND_IO_IN, 8'h16, 8'h26);
    acc(iod_pkg::KIND_CLR_BIT, 8'h16, 3'h5, 8'h00);
    rdchk(iod_pkg::KIND_IO_IN, 8'h16, 8'h26);
    pulse(4, 8'hFF);
    acc(iod_pkg::KIND_IO_OUT, 8'h1C, 3'h0, 8'h0F);
    rdchk(iod_pkg::KIND_IO_IN, 8'h1C, 8'hF0);
    acc(iod_pkg::KIND_IO_OUT, 8'h1C, 3'h0, 8'h00);
    rdchk(iod_pkg::KIND_IO_IN, 8'h1C, 8'hF0);
    // hardware set in the cycle of a written one wins
    fork
      pulse(4, 8'h01);
      acc(iod_pkg::KIND_IO_OUT, 8'h1C, 3'h0, 8'h01);
    join
    rdchk(iod_pkg::KIND_IO_IN, 8'h1C, 8'hF1);
    // bit set, clear and test on a port register
    acc(iod_pkg::KIND_IO_OUT, 8'h02, 3'h0, 8'hA5);
    acc(iod_pkg::KIND_SET_BIT, 8'h02, 3'h1, 8'h00);
    acc(iod_pkg::KIND_CLR_BIT, 8'h02, 3'h7, 8'h00);
    rdchk(iod_pkg::KIND_IO_IN, 8'h02, 8'h27);
    v = 8'h27;
    for (int b = 0; b < 8; b++) begin
      acc(iod_pkg::KIND_SKIP_SET, 8'h02, 3'(b), 8'h00);
      chk(rsp.skip, v[b]);
      acc(iod_pkg::KIND_SKIP_CLR, 8'h02, 3'(b), 8'h00);
      chk(rsp.skip, !v[b]);
    end
    // refusals above the bit range and the io range
    acc(iod_pkg::KIND_IO_OUT, 8'h20, 3'h0, 8'h00);
    acc(iod_pkg::KIND_SET_BIT, 8'h20, 3'h0, 8'h00);
    chk(rsp.refused, 1'b1);
    rdchk(iod_pkg::KIND_IO_IN, 8'h20, 8'h00);
    acc(iod_pkg::KIND_SKIP_CLR, 8'h20, 3'h0, 8'h00);
    chk({rsp.refused, rsp.skip}, 2'b10);
    acc(iod_pkg::KIND_IO_IN, 8'h40, 3'h0, 8'h00);
    chk(rsp.refused, 1'b1);
    acc(iod_pkg::KIND_IO_IN, 8'h3F, 3'h0, 8'h00);
    chk({rsp.refused, rsp.rdata}, 9'h000);
    // extended region only through loads and stores
    acc(iod_pkg::KIND_DATA_LOAD, 8'h60, 3'h0, 8'h00);
    chk({rsp.ext, rsp.refused}, 2'b10);
    acc(iod_pkg::KIND_DATA_STORE, 8'hFF, 3'h0, 8'h55);
    chk({rsp.ext, rsp.refused}, 2'b10);
    acc(iod_pkg::KIND_IO_OUT, 8'h60, 3'h0, 8'h55);
    chk(rsp.refused, 1'b1);
    stop_test;
  end
endmodule : iod_io_decoder_bench
`default_nettype wire
